// ### iatc_part_model.sv
// Far side: table memory and I/O module presence responder.
// Assumes the loader holds probe_kind and probe_addr steady while it waits.
module iatc_part_model (
  input wire logic [7:0] tbl_addr,
  output logic [15:0] tbl_data,
  input wire logic probe_req,
  input wire logic [1:0] probe_kind,
  input wire logic [7:0] probe_addr,
  input wire logic miss_en,
  input wire logic [1:0] miss_kind,
  input wire logic [7:0] miss_addr,
  output logic probe_ack
);
  // ----------------------------------------------------------------
  // Memory and presence
  // ----------------------------------------------------------------
  logic [15:0] mem [256];
  // Combinational read, so the word is settled long before its sampling edge
  assign tbl_data = mem[tbl_addr];
  // One absent byte at most, so every stop has a single known cause
  // Answers only while asked, so a lost probe request also ends in stop
  assign probe_ack = probe_req &&
    !(miss_en && probe_kind == miss_kind && probe_addr == miss_addr);
endmodule // iatc_part_model

// ### iatc_pkg.sv
// Constants for the I/O assignment table checker.
// Assumes a 16-bit table memory read port and byte-wide module presence probe.
package iatc_pkg;
  // ----------------------------------------------------------------
  // Table words
  // ----------------------------------------------------------------
  localparam logic [15:0] SIG0 = 16'h4d41;
  localparam logic [15:0] SIG1 = 16'h534b;
  localparam logic [15:0] SIG2 = 16'h3031;
  localparam logic [15:0] ID_IN = 16'hde00;
  localparam logic [15:0] ID_OUT = 16'hda00;
  localparam logic [15:0] ID_FIN = 16'hce00;
  localparam logic [15:0] ID_FOUT = 16'hca00;
  localparam logic [15:0] ID_END = 16'heeee;
  localparam logic [7:0] FIRST_AREA_POS = 8'h03;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_BASE = 16'hf000;
  localparam logic [15:0] IO_TOP = 16'hffff;
  localparam logic [7:0] IMAGE_TOP = 8'h7f;
  // ----------------------------------------------------------------
  // Area kinds and indicator timing
  // ----------------------------------------------------------------
  localparam logic [1:0] AREA_IN = 2'h0;
  localparam logic [1:0] AREA_OUT = 2'h1;
  localparam logic [1:0] AREA_FIN = 2'h2;
  localparam logic [1:0] AREA_FOUT = 2'h3;
  localparam int BLINK_PERIOD_MS = 1000;
  localparam int CLK_MHZ = 100;
  localparam int BLINK_HALF_CYCLES = BLINK_PERIOD_MS * 1000 * CLK_MHZ / 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SIG = 3'h1,
    ST_AREA = 3'h2,
    ST_PROBE = 3'h3,
    ST_RUN = 3'h4,
    ST_STOP = 3'h5,
    ST_REFRESH = 3'h6
  } iatc_state_e;
endpackage : iatc_pkg

// ### iatc_top.sv
// Loader and access checker for the I/O assignment table.
// Assumes table memory answers a read in the same cycle as tbl_addr, and a presence
// probe answers in the same cycle as probe_req with probe_ack for probe_addr.
// Function
// RULE1: Peripheral region F000H-FFFFH is one shared range
// RULE2: Table always required, empty table allowed
// RULE3: Table lists I/O 0-127 and flag bytes
// RULE4: Refresh only listed image bytes
// RULE5: Table loaded only at cold restart
// RULE6: Signatures 4D41, 534B, 3031 at words 0-2
// RULE7: Area identifier precedes each list from word 3
// RULE8: DE00 inputs, DA00 outputs
// RULE9: CE00 flag inputs, CA00 flag outputs
// RULE10: Each entry is one signed byte-number word
// RULE11: EEEE ends the table
// RULE12: Refresh last stored entry first
// RULE13: Duplicates refreshed once per occurrence
// RULE14: Missing byte stops, blinks indicator slowly
// RULE15: Unlisted image access gives addressing error
// RULE16: Direct loads always allowed if acknowledged
// RULE17: Direct writes 0-127 need listed output
// RULE18: Direct writes above 127 unchecked
// RULE19: Extended direct writes always allowed
// RULE20: Flag output byte owned by one processor (not checked here; FOUT entries are only probed and refreshed)
// RULE21: Bad signature or no end stops
module iatc_top #(
  parameter int TBL_DEPTH = 256,
  parameter int BLINK_CYCLES = iatc_pkg::BLINK_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cold_restart,
  output logic [7:0] tbl_addr,
  input wire logic [15:0] tbl_data,
  output logic probe_req,
  output logic [1:0] probe_kind,
  output logic [7:0] probe_addr,
  input wire logic probe_ack,
  input wire logic refresh_start,
  output logic refresh_valid,
  output logic [1:0] refresh_kind,
  output logic [7:0] refresh_byte,
  output logic refresh_done,
  input wire logic acc_valid,
  input wire logic acc_image,
  input wire logic acc_write,
  input wire logic acc_ext,
  input wire logic acc_ack,
  input wire logic [7:0] acc_byte,
  output logic acc_grant,
  output logic acc_addr_error,
  output logic acc_image_update,
  output logic running,
  output logic stop_state,
  output logic stop_led,
  output logic [15:0] bus_addr
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iatc_pkg::iatc_state_e state_reg, state_next;
  logic [7:0] pos_reg, pos_next;
  logic [1:0] area_reg, area_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] ridx_reg, ridx_next;
  logic [31:0] blink_reg, blink_next;
  logic led_reg, led_next;
  logic probe_reg, probe_next;
  logic [1:0] pkind_reg, pkind_next;
  logic [7:0] paddr_reg, paddr_next;
  logic rv_reg, rv_next, rd_reg, rd_next;
  logic [1:0] rk_reg, rk_next;
  logic [7:0] rb_reg, rb_next;
  logic tbl_pend_reg, tbl_pend_next;
  // Entry list kept in storage order so refresh can walk it backwards
  logic [9:0] ent_mem [TBL_DEPTH];
  logic ent_we;
  logic [9:0] ent_wdata;
  logic [127:0] in_map_reg, in_map_next, out_map_reg, out_map_next;
  logic stop_req;
  logic run_reg, run_next, stp_reg, stp_next;

  function automatic logic in_range(input logic [15:0] w);
    in_range = (w[15:8] == 8'h00);
  endfunction

  // ----------------------------------------------------------------
  // Loader sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pos_next = pos_reg;
    area_next = area_reg;
    cnt_next = cnt_reg;
    ridx_next = ridx_reg;
    probe_next = 1'b0;
    pkind_next = pkind_reg;
    paddr_next = paddr_reg;
    rv_next = 1'b0;
    rd_next = 1'b0;
    rk_next = rk_reg;
    rb_next = rb_reg;
    tbl_pend_next = 1'b0;
    in_map_next = in_map_reg;
    out_map_next = out_map_reg;
    ent_we = 1'b0;
    ent_wdata = {area_reg, tbl_data[7:0]};
    stop_req = 1'b0;
    if (cold_restart) begin
      // Table only taken in here; edits made after loading have no effect until the next one
      state_next = iatc_pkg::ST_SIG; // RULE5
      pos_next = 8'h00;
      cnt_next = 8'h00;
      in_map_next = '0;
      out_map_next = '0;
      tbl_pend_next = 1'b1;
    end else begin
      case (state_reg)
        iatc_pkg::ST_IDLE: begin
          // No table taken yet, so every access stays refused
          state_next = iatc_pkg::ST_IDLE; // RULE2
        end
        iatc_pkg::ST_SIG: begin
          tbl_pend_next = 1'b1;
          if (tbl_pend_reg) begin
            if ((pos_reg == 8'h00 && tbl_data != iatc_pkg::SIG0) || // RULE6
                (pos_reg == 8'h01 && tbl_data != iatc_pkg::SIG1) ||
                (pos_reg == 8'h02 && tbl_data != iatc_pkg::SIG2)) begin
              stop_req = 1'b1; // RULE21
            end else begin
              pos_next = pos_reg + 8'h01;
              if (pos_reg == 8'h02) state_next = iatc_pkg::ST_AREA; // RULE7
            end
          end
        end
        iatc_pkg::ST_AREA: begin
          tbl_pend_next = 1'b1;
          if (tbl_pend_reg) begin
            pos_next = pos_reg + 8'h01;
            if (tbl_data == iatc_pkg::ID_END) begin
              state_next = iatc_pkg::ST_RUN; // RULE11
            end else if (tbl_data == iatc_pkg::ID_IN) begin
              area_next = iatc_pkg::AREA_IN; // RULE8
            end else if (tbl_data == iatc_pkg::ID_OUT) begin
              area_next = iatc_pkg::AREA_OUT; // RULE8
            end else if (tbl_data == iatc_pkg::ID_FIN) begin
              area_next = iatc_pkg::AREA_FIN; // RULE9
            end else if (tbl_data == iatc_pkg::ID_FOUT) begin
              area_next = iatc_pkg::AREA_FOUT; // RULE9
            end else if (!in_range(tbl_data) || pos_reg == iatc_pkg::FIRST_AREA_POS ||
                         cnt_reg == 8'(TBL_DEPTH - 1) || pos_reg == 8'hff) begin
              // Entry before any identifier, negative, or table overrun
              stop_req = 1'b1; // RULE21
            end else begin
              // Each entry word is one byte number
              ent_we = 1'b1; // RULE10
              cnt_next = cnt_reg + 8'h01;
              probe_next = 1'b1;
              pkind_next = area_reg;
              paddr_next = tbl_data[7:0];
              tbl_pend_next = 1'b0;
              state_next = iatc_pkg::ST_PROBE;
              if (area_reg == iatc_pkg::AREA_IN && !tbl_data[7]) begin
                in_map_next[tbl_data[6:0]] = 1'b1; // RULE3
              end
              if (area_reg == iatc_pkg::AREA_OUT && !tbl_data[7]) begin
                out_map_next[tbl_data[6:0]] = 1'b1; // RULE3
              end
            end
          end
        end
        iatc_pkg::ST_PROBE: begin
          // Probe answers in the same cycle as probe_req; absent byte halts the program
          if (probe_ack) begin
            state_next = iatc_pkg::ST_AREA;
            tbl_pend_next = 1'b1;
          end else begin
            stop_req = 1'b1; // RULE14
          end
        end
        iatc_pkg::ST_RUN: begin
          if (refresh_start) begin
            ridx_next = cnt_reg;
            state_next = iatc_pkg::ST_REFRESH;
          end
        end
        iatc_pkg::ST_REFRESH: begin
          // Walk from last stored entry; duplicates come out each time
          if (ridx_reg == 8'h00) begin
            rd_next = 1'b1;
            state_next = iatc_pkg::ST_RUN;
          end else begin
            rv_next = 1'b1; // RULE12 RULE13
            rk_next = ent_mem[ridx_reg - 8'h01][9:8];
            rb_next = ent_mem[ridx_reg - 8'h01][7:0]; // RULE4
            ridx_next = ridx_reg - 8'h01;
          end
        end
        iatc_pkg::ST_STOP: begin
          state_next = iatc_pkg::ST_STOP;
        end
        default: begin
          state_next = iatc_pkg::ST_IDLE;
        end
      endcase
      if (stop_req) state_next = iatc_pkg::ST_STOP;
    end
    // Status outputs registered from the next state, so they track it without delay
    run_next = (state_next == iatc_pkg::ST_RUN) || (state_next == iatc_pkg::ST_REFRESH);
    stp_next = (state_next == iatc_pkg::ST_STOP);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= iatc_pkg::ST_IDLE;
      pos_reg <= 8'h00;
      area_reg <= iatc_pkg::AREA_IN;
      cnt_reg <= 8'h00;
      ridx_reg <= 8'h00;
      probe_reg <= 1'b0;
      pkind_reg <= 2'h0;
      paddr_reg <= 8'h00;
      rv_reg <= 1'b0;
      rd_reg <= 1'b0;
      rk_reg <= 2'h0;
      rb_reg <= 8'h00;
      tbl_pend_reg <= 1'b0;
      in_map_reg <= '0;
      out_map_reg <= '0;
      run_reg <= 1'b0;
      stp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      area_reg <= area_next;
      cnt_reg <= cnt_next;
      ridx_reg <= ridx_next;
      probe_reg <= probe_next;
      pkind_reg <= pkind_next;
      paddr_reg <= paddr_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rk_reg <= rk_next;
      rb_reg <= rb_next;
      tbl_pend_reg <= tbl_pend_next;
      in_map_reg <= in_map_next;
      out_map_reg <= out_map_next;
      run_reg <= run_next;
      stp_reg <= stp_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ent_we) ent_mem[cnt_reg] <= ent_wdata;
  end

  // ----------------------------------------------------------------
  // Access checking
  // ----------------------------------------------------------------
  logic grant_reg, grant_next, err_reg, err_next, upd_reg, upd_next;
  logic [15:0] baddr_reg, baddr_next;
  logic listed_out, listed_in, low_byte;
  always_comb begin
    low_byte = (acc_byte <= iatc_pkg::IMAGE_TOP);
    listed_out = low_byte && out_map_reg[acc_byte[6:0]];
    listed_in = low_byte && in_map_reg[acc_byte[6:0]];
    grant_next = 1'b0;
    err_next = 1'b0;
    upd_next = 1'b0;
    baddr_next = baddr_reg;
    if (acc_valid && state_reg == iatc_pkg::ST_RUN) begin
      // Every access lands in the one shared window
      baddr_next = iatc_pkg::IO_BASE | {8'h00, acc_byte}; // RULE1
      if (acc_image) begin
        if ((acc_write && listed_out) || (!acc_write && listed_in)) begin
          grant_next = 1'b1;
        end else begin
          err_next = 1'b1; // RULE15
        end
      end else if (!acc_write) begin
        grant_next = acc_ack; // RULE16
      end else if (acc_ext) begin
        grant_next = 1'b1; // RULE19
      end else if (!low_byte) begin
        grant_next = 1'b1; // RULE18
      end else if (listed_out) begin
        grant_next = 1'b1; // RULE17
        upd_next = 1'b1; // RULE17
      end else begin
        err_next = 1'b1; // RULE17
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      grant_reg <= 1'b0;
      err_reg <= 1'b0;
      upd_reg <= 1'b0;
      baddr_reg <= iatc_pkg::IO_BASE;
    end else begin
      grant_reg <= grant_next;
      err_reg <= err_next;
      upd_reg <= upd_next;
      baddr_reg <= baddr_next;
    end
  end

  // ----------------------------------------------------------------
  // Stop indicator
  // ----------------------------------------------------------------
  // Slow blink only in stop; steady off otherwise
  always_comb begin
    blink_next = 32'h0;
    led_next = 1'b0;
    if (state_reg == iatc_pkg::ST_STOP) begin
      led_next = led_reg;
      blink_next = blink_reg + 32'h1;
      if (blink_reg >= 32'(BLINK_CYCLES - 1)) begin
        blink_next = 32'h0;
        led_next = !led_reg; // RULE14
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      blink_reg <= 32'h0;
      led_reg <= 1'b0;
    end else begin
      blink_reg <= blink_next;
      led_reg <= led_next;
    end
  end

  assign tbl_addr = pos_reg;
  assign probe_req = probe_reg;
  assign probe_kind = pkind_reg;
  assign probe_addr = paddr_reg;
  assign refresh_valid = rv_reg;
  assign refresh_kind = rk_reg;
  assign refresh_byte = rb_reg;
  assign refresh_done = rd_reg;
  assign acc_grant = grant_reg;
  assign acc_addr_error = err_reg;
  assign acc_image_update = upd_reg;
  assign running = run_reg;
  assign stop_state = stp_reg;
  assign stop_led = led_reg;
  assign bus_addr = baddr_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_probe_miss;
    state_reg == iatc_pkg::ST_PROBE && !probe_ack && !cold_restart;
  endsequence
  a_missing_byte_stop: assert property (@(posedge core_clk) disable iff (reset) // RULE14
    s_probe_miss |=> stop_state) else $error("missing byte did not stop");
  a_image_unlisted_err: assert property (@(posedge core_clk) disable iff (reset) // RULE15
    acc_valid && running && !refresh_valid && state_reg == iatc_pkg::ST_RUN && acc_image &&
    !acc_write && !(acc_byte <= iatc_pkg::IMAGE_TOP && in_map_reg[acc_byte[6:0]])
    |=> acc_addr_error && !acc_grant) else $error("unlisted image read not flagged");
  a_direct_load_ok: assert property (@(posedge core_clk) disable iff (reset) // RULE16
    state_reg == iatc_pkg::ST_RUN && acc_valid && !acc_image && !acc_write && acc_ack
    |=> acc_grant) else $error("direct load refused");
  a_high_write_ok: assert property (@(posedge core_clk) disable iff (reset) // RULE18
    state_reg == iatc_pkg::ST_RUN && acc_valid && !acc_image && acc_write && acc_byte > 8'h7f
    |=> acc_grant && !acc_image_update) else $error("high direct write mishandled");
  a_ext_write_ok: assert property (@(posedge core_clk) disable iff (reset) // RULE19
    state_reg == iatc_pkg::ST_RUN && acc_valid && !acc_image && acc_write && acc_ext
    |=> acc_grant && !acc_addr_error) else $error("extended write refused");
  a_low_write_check: assert property (@(posedge core_clk) disable iff (reset) // RULE17
    state_reg == iatc_pkg::ST_RUN && acc_valid && !acc_image && acc_write && !acc_ext &&
    acc_byte <= 8'h7f |=> acc_grant == acc_image_update && acc_grant != acc_addr_error)
    else $error("low direct write mishandled");
  a_bad_sig_stop: assert property (@(posedge core_clk) disable iff (reset) // RULE21
    state_reg == iatc_pkg::ST_SIG && tbl_pend_reg && !cold_restart && pos_reg == 8'h00 &&
    tbl_data != iatc_pkg::SIG0 |=> stop_state) else $error("bad signature accepted");
  a_end_to_run: assert property (@(posedge core_clk) disable iff (reset) // RULE11
    state_reg == iatc_pkg::ST_AREA && tbl_pend_reg && !cold_restart &&
    tbl_data == iatc_pkg::ID_END |=> running) else $error("end marker not taken");
  a_refresh_order: assert property (@(posedge core_clk) disable iff (reset) // RULE12
    state_reg == iatc_pkg::ST_REFRESH && ridx_reg != 8'h00 && !cold_restart
    |=> refresh_valid && ridx_reg == $past(ridx_reg) - 8'h01) else $error("refresh order");
endmodule // iatc_top

// ### iatc_top_tb_top.sv
// Self-checking bench for the table checker.
// Assumes the partner model answers table reads and presence probes.
module iatc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] m; logic [2:0] v; logic [15:0] a;} iatc_exp_s;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 0, reset = 1, cold_restart = 0, refresh_start = 0, pend = 0;
  logic acc_valid = 0, acc_image = 0, acc_write = 0, acc_ext = 0, acc_ack = 0;
  logic [7:0] acc_byte = 8'h00, miss_addr = 8'h00, tbl_addr, probe_addr, refresh_byte, rb;
  logic [15:0] tbl_data, bus_addr;
  logic [1:0] miss_kind = 2'h0, probe_kind, refresh_kind;
  logic miss_en = 0, probe_req, probe_ack, refresh_valid, refresh_done, acc_grant;
  logic acc_addr_error, acc_image_update, running, stop_state, stop_led, led_prev;
  int err_count = 0, compares = 0, seed = 18, cycles = 0, tg;
  iatc_exp_s aq[$];
  iatc_exp_s ex;
  logic [9:0] rq[$];
  logic [9:0] rr;
  logic [15:0] tq[$];
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // Short blink half period keeps the stop checks quick
  iatc_top #(.TBL_DEPTH(256), .BLINK_CYCLES(4)) uut (.core_clk, .reset, .cold_restart,
    .tbl_addr, .tbl_data, .probe_req, .probe_kind, .probe_addr, .probe_ack, .refresh_start,
    .refresh_valid, .refresh_kind, .refresh_byte, .refresh_done, .acc_valid, .acc_image,
    .acc_write, .acc_ext, .acc_ack, .acc_byte, .acc_grant, .acc_addr_error,
    .acc_image_update, .running, .stop_state, .stop_led, .bus_addr);
  iatc_part_model part (.tbl_addr, .tbl_data, .probe_req, .probe_kind, .probe_addr, .miss_en,
    .miss_kind, .miss_addr, .probe_ack);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task start(input logic exp_stop);
    int n;
    foreach (tq[i]) part.mem[i] = tq[i];
    @(posedge core_clk);
    cold_restart <= 1;
    @(posedge core_clk);
    cold_restart <= 0;
    cyc(2);
    n = 0;
    while (!(running === 1'b1 || stop_state === 1'b1) && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    cyc(1);
    check(stop_state, exp_stop, "stop_state");
    check(running, !exp_stop, "running");
  endtask
  task acc(input logic im, wr, ex_r, ak, input logic [7:0] b, input logic [2:0] v, m);
    @(posedge core_clk);
    acc_valid <= 1;
    acc_image <= im;
    acc_write <= wr;
    acc_ext <= ex_r;
    acc_ack <= ak;
    acc_byte <= b;
    aq.push_back({m, v, 8'hf0, b});
  endtask
  task idle;
    @(posedge core_clk);
    acc_valid <= 0;
    cyc(3);
  endtask
  task refresh;
    int k;
    @(posedge core_clk);
    refresh_start <= 1;
    @(posedge core_clk);
    refresh_start <= 0;
    k = 0;
    while (refresh_done !== 1'b1 && k < 500) begin
      @(posedge core_clk);
      k++;
    end
    cyc(1);
    check(rq.size(), 0, "refresh count");
  endtask
  // ----------------------------------------------------------------
  // Watchers
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  always @(posedge core_clk) begin
    if (pend) begin
      ex = aq.pop_front();
      check({acc_grant, acc_addr_error, acc_image_update} & ex.m, ex.v, "access");
      if (ex.v[2:1] != 2'b00) check(bus_addr, ex.a, "bus_addr");
    end
    pend <= acc_valid;
    if (refresh_valid === 1'b1) begin
      rr = (rq.size() > 0) ? rq.pop_front() : 10'h3ff;
      check({refresh_kind, refresh_byte}, rr, "refresh");
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    reset <= 0;
    tq = '{iatc_pkg::SIG0, iatc_pkg::SIG1, iatc_pkg::SIG2, iatc_pkg::ID_IN, 16'h0001,
      16'h0003, 16'h0007, 16'h0003, iatc_pkg::ID_OUT, 16'h0002, 16'h000c, iatc_pkg::ID_END};
    start(0);
    rq = '{{iatc_pkg::AREA_OUT, 8'h0c}, {iatc_pkg::AREA_OUT, 8'h02}, {iatc_pkg::AREA_IN, 8'h03},
      {iatc_pkg::AREA_IN, 8'h07}, {iatc_pkg::AREA_IN, 8'h03}, {iatc_pkg::AREA_IN, 8'h01}};
    refresh();
    acc(1, 0, 0, 1, 8'h07, 3'b100, 3'b110);
    acc(1, 0, 0, 1, 8'h05, 3'b010, 3'b110);
    acc(1, 1, 0, 1, 8'h0c, 3'b100, 3'b110);
    acc(1, 1, 0, 1, 8'h03, 3'b010, 3'b110);
    acc(0, 1, 0, 1, 8'h02, 3'b101, 3'b111);
    acc(0, 1, 0, 1, 8'h7f, 3'b010, 3'b111);
    rb = $random(seed);
    acc(0, 1, 0, 1, 8'h80 | rb, 3'b100, 3'b111);
    rb = $random(seed);
    acc(0, 1, 1, 1, rb, 3'b100, 3'b111);
    acc(0, 0, 0, 1, 8'h09, 3'b100, 3'b110);
    acc(0, 0, 0, 0, 8'h09, 3'b000, 3'b111);
    idle();
    // Table edited while running must stay without effect until reload
    part.mem[4] = 16'h0005;
    acc(1, 0, 0, 1, 8'h05, 3'b010, 3'b110);
    idle();
    tq = {};
    start(0);
    acc(1, 0, 0, 1, 8'h05, 3'b100, 3'b110);
    acc(1, 0, 0, 1, 8'h01, 3'b010, 3'b110);
    idle();
    tq = '{iatc_pkg::SIG0, iatc_pkg::SIG1, iatc_pkg::SIG2, iatc_pkg::ID_FIN, 16'h0032,
      iatc_pkg::ID_FOUT, 16'h0046, iatc_pkg::ID_END};
    start(0);
    miss_en <= 1;
    miss_kind <= iatc_pkg::AREA_FOUT;
    miss_addr <= 8'h46;
    start(1);
    tg = 0;
    repeat (20) begin
      led_prev = stop_led;
      @(posedge core_clk);
      if (stop_led !== led_prev) tg++;
    end
    check(tg >= 4 && tg <= 6, 1, "stop_led toggles");
    acc(0, 1, 0, 1, 8'h02, 3'b000, 3'b111);
    idle();
    miss_en <= 0;
    tq = '{iatc_pkg::SIG0, iatc_pkg::SIG1, 16'h3032, iatc_pkg::ID_END};
    start(1);
    tq = '{iatc_pkg::SIG0, iatc_pkg::SIG1, iatc_pkg::SIG2, iatc_pkg::ID_IN};
    for (int i = 4; i < 256; i++) tq.push_back(16'h0001);
    start(1);
    tq = '{iatc_pkg::SIG0, iatc_pkg::SIG1, iatc_pkg::SIG2, iatc_pkg::ID_END};
    start(0);
    rq = {};
    refresh();
    wrap_up();
  end
endmodule // iatc_top_tb_top
